/* File: hw/sensor_device.sv */
/*
  Sensor end of the three-wire link: instruction framing, reset pattern
  hunt, conversion sequencing and result or calibration shift-out.
  Assumes all link inputs are asynchronous to CLOCK; the analogue front
  end is stood in for by the two level inputs.
*/
// Summary of operation
// - Sample din, launch dout on sclk rise
// - Host samples and changes on sclk fall
// - Only the host drives the serial clock
// - Dout carries selected data and conversion status
// - Frame is start 111, setup, stop 000
// - Setup decodes to six operations
// - Raise dout on last stop bit of a conversion frame
// - Host gives two pulses, then holds low
// - Dout falling marks end of conversion
// - Host reads result with seventeen pulses
// - Readout survives a paused serial clock
// - Host reads result before next conversion
// - Reset pattern returns to idle anywhere
// - Host ignores dout during reset pattern
// - Host sends reset before each conversion
// - Four sixteen-bit calibration words held
// - One converter makes both sixteen-bit results
// - Bridge powered only in short bursts
// - Host reads calibration words once
// - Results lie within 5000 to 37000
// - Host may stop conversion clock idle
`timescale 1ns/1ps
`include "sensor_link_defines.svh"

module sensor_device #(
  parameter int CONV_EDGES = `CONV_MCLK_EDGES
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  sensor_link_if.device LINK,
  input wire logic [15:0] PRESSURE_LEVEL,
  input wire logic [15:0] TEMPERATURE_LEVEL,
  output logic BRIDGE_POWER,
  output logic CONVERTING
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Setup code to operation; bit 3 marks a valid code
  function automatic logic [3:0] decode_setup(input logic [3:0] code);
    unique case (code)
      `SETUP_PRESSURE: decode_setup = {1'b1, sensor_link_pkg::OP_PRESSURE};
      `SETUP_TEMPERATURE:
        decode_setup = {1'b1, sensor_link_pkg::OP_TEMPERATURE};
      `SETUP_CAL_A: decode_setup = {1'b1, sensor_link_pkg::OP_CAL_A};
      `SETUP_CAL_B: decode_setup = {1'b1, sensor_link_pkg::OP_CAL_B};
      `SETUP_CAL_C: decode_setup = {1'b1, sensor_link_pkg::OP_CAL_C};
      `SETUP_CAL_D: decode_setup = {1'b1, sensor_link_pkg::OP_CAL_D};
      default: decode_setup = 4'h0;
    endcase
  endfunction : decode_setup

  // Factory words are fixed at build time, standing in for the PROM
  function automatic logic [15:0] cal_word(input sensor_link_pkg::op_t op);
    unique case (op)
      sensor_link_pkg::OP_CAL_A: cal_word = `CAL_SLOT_A_INIT;
      sensor_link_pkg::OP_CAL_B: cal_word = `CAL_SLOT_B_INIT;
      sensor_link_pkg::OP_CAL_C: cal_word = `CAL_SLOT_C_INIT;
      default: cal_word = `CAL_SLOT_D_INIT;
    endcase
  endfunction : cal_word

  // Keep converter output inside its physical count range
  function automatic logic [15:0] clamp(input logic [15:0] level);
    if (level < `RESULT_MIN) begin
      clamp = `RESULT_MIN;
    end else if (level > `RESULT_MAX) begin
      clamp = `RESULT_MAX;
    end else begin
      clamp = level;
    end
  endfunction : clamp

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic sclk_meta;
  logic sclk_sync;
  logic sclk_prev;
  logic din_meta;
  logic din_sync;
  logic mclk_meta;
  logic mclk_sync;
  logic mclk_prev;
  logic sclk_rise;
  logic mclk_rise;

  // Two flops on every pin; edge detect looks at the second only
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_prev <= 1'b0;
      din_meta <= 1'b0;
      din_sync <= 1'b0;
      mclk_meta <= 1'b0;
      mclk_sync <= 1'b0;
      mclk_prev <= 1'b0;
    end else begin
      sclk_meta <= LINK.sclk;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
      din_meta <= LINK.din;
      din_sync <= din_meta;
      mclk_meta <= LINK.mclk;
      mclk_sync <= mclk_meta;
      mclk_prev <= mclk_sync;
    end
  end

  assign sclk_rise = sclk_sync & ~sclk_prev;
  assign mclk_rise = mclk_sync & ~mclk_prev;

  // ****************************************************************
  // Protocol engine
  // ****************************************************************
  sensor_link_pkg::dev_state_t state;
  sensor_link_pkg::dev_state_t next_state;
  sensor_link_pkg::op_t op;
  sensor_link_pkg::op_t next_op;
  logic [20:0] history;
  logic [20:0] next_history;
  logic [10:0] count;
  logic [10:0] next_count;
  logic [15:0] shift_out;
  logic [15:0] next_shift_out;
  logic dout;
  logic next_dout;
  logic next_bridge;
  logic next_converting;
  logic [20:0] hist_in;
  logic [3:0] decoded;
  logic frame_ok;

  assign hist_in = {history[19:0], din_sync};
  assign decoded = decode_setup(hist_in[6:3]);
  assign frame_ok = (hist_in[9:7] == `START_MARK)
                  & (hist_in[2:0] == `STOP_MARK) & decoded[3];

  // Next-state logic; the reset pattern overrides every state
  always_comb begin
    next_state = state;
    next_op = op;
    next_history = history;
    next_count = count;
    next_shift_out = shift_out;
    next_dout = dout;
    next_bridge = 1'b0;
    next_converting = 1'b0;
    if (sclk_rise) begin
      next_history = hist_in;
    end
    if (sclk_rise && hist_in == `RESET_PATTERN) begin
      next_state = sensor_link_pkg::D_IDLE;
      next_history = 21'h000000;
      next_dout = 1'b0;
    end else begin
      unique case (state)
        sensor_link_pkg::D_IDLE: begin
          if (sclk_rise && frame_ok) begin
            next_op = sensor_link_pkg::op_t'(decoded[2:0]);
            next_history = 21'h000000;
            if (decoded[2:1] == 2'h0) begin
              next_dout = 1'b1;
              next_count = `ACK_TAIL_PULSES;
              next_state = sensor_link_pkg::D_ACK_TAIL;
            end else begin
              next_shift_out = cal_word(sensor_link_pkg::op_t'(decoded[2:0]));
              next_count = `READ_PULSES;
              next_state = sensor_link_pkg::D_SHIFT;
            end
          end
        end
        sensor_link_pkg::D_ACK_TAIL: begin
          // Conversion starts after the two trailing pulses
          if (sclk_rise) begin
            next_count = count - 11'h001;
            if (count == 11'h001) begin
              next_count = 11'(CONV_EDGES);
              next_state = sensor_link_pkg::D_CONVERT;
            end
          end
        end
        sensor_link_pkg::D_CONVERT: begin
          next_converting = 1'b1;
          // One slot in sixteen; the last slot always, so short runs too
          next_bridge = (count[`BRIDGE_DUTY_BITS-1:0] == 4'h1);
          if (mclk_rise) begin
            next_count = count - 11'h001;
            if (count == 11'h001) begin
              next_dout = 1'b0;
              next_bridge = 1'b0;
              next_converting = 1'b0;
              next_shift_out = (op == sensor_link_pkg::OP_PRESSURE) ?
                clamp(PRESSURE_LEVEL) : clamp(TEMPERATURE_LEVEL);
              next_count = `READ_PULSES;
              next_state = sensor_link_pkg::D_SHIFT;
            end
          end
        end
        sensor_link_pkg::D_SHIFT: begin
          // Waits on sclk edges only, so a held clock just pauses
          if (sclk_rise) begin
            next_dout = shift_out[15];
            next_shift_out = {shift_out[14:0], 1'b0};
            next_count = count - 11'h001;
            if (count == 11'h001) begin
              next_dout = 1'b0;
              next_history = 21'h000000;
              next_state = sensor_link_pkg::D_IDLE;
            end
          end
        end
        default: begin
          next_state = sensor_link_pkg::D_IDLE;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state <= sensor_link_pkg::D_IDLE;
      op <= sensor_link_pkg::OP_PRESSURE;
      history <= 21'h000000;
      count <= 11'h000;
      shift_out <= 16'h0000;
      dout <= 1'b0;
      BRIDGE_POWER <= 1'b0;
      CONVERTING <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      history <= next_history;
      count <= next_count;
      shift_out <= next_shift_out;
      dout <= next_dout;
      BRIDGE_POWER <= next_bridge;
      CONVERTING <= next_converting;
    end
  end

  assign LINK.dout = dout;

endmodule : sensor_device

/* File: hw/sensor_link_defines.svh */
/*
  Constants for the three-wire sensor link: timing, framing, codes.
  Assumes a 20 MHz system clock on both ends of the link.
*/
`ifndef SENSOR_LINK_DEFINES_SVH
`define SENSOR_LINK_DEFINES_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CLOCK_HZ 20000000
`define SCLK_MAX_HZ 500000
`define SCLK_HALF_CYCLES (`CLOCK_HZ / (2 * `SCLK_MAX_HZ))
`define MCLK_HZ 32768
`define MCLK_HALF_CYCLES (`CLOCK_HZ / (2 * `MCLK_HZ))
`define CONV_TIME_US 35000
`define CONV_MCLK_EDGES (`CONV_TIME_US * `MCLK_HZ / 1000000)
`define BRIDGE_DUTY_BITS 4

// ****************************************************************
// Framing and setup codes
// ****************************************************************
`define START_MARK 3'h7
`define STOP_MARK 3'h0
`define ACK_TAIL_PULSES 11'h002
`define READ_PULSES 11'h011
`define FRAME_PULSES 5'h1f
`define SETUP_PRESSURE 4'h4
`define SETUP_TEMPERATURE 4'h2
`define SETUP_CAL_A 4'h5
`define SETUP_CAL_B 4'h6
`define SETUP_CAL_C 4'h9
`define SETUP_CAL_D 4'ha
`define RESET_PATTERN 21'h155555

// ****************************************************************
// Calibration storage and result range
// ****************************************************************
`define CAL_SLOT_A_INIT 16'h1234
`define CAL_SLOT_B_INIT 16'h5678
`define CAL_SLOT_C_INIT 16'h9abc
`define CAL_SLOT_D_INIT 16'hdef0
`define RESULT_MIN 16'h1388
`define RESULT_MAX 16'h9088

`endif

/* File: hw/sensor_link_pkg.sv */
/*
  Types shared by both ends of the sensor link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sensor_link_pkg;

  // ****************************************************************
  // Operations and states
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_PRESSURE = 3'h0,
    OP_TEMPERATURE = 3'h1,
    OP_CAL_A = 3'h2,
    OP_CAL_B = 3'h3,
    OP_CAL_C = 3'h4,
    OP_CAL_D = 3'h5
  } op_t;

  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_ACK_TAIL = 3'h1,
    D_CONVERT = 3'h2,
    D_SHIFT = 3'h3
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_FRAME = 3'h1,
    H_TAIL = 3'h2,
    H_WAIT = 3'h3,
    H_READ = 3'h4
  } host_state_t;

endpackage : sensor_link_pkg

/* File: hw/sensor_link_if.sv */
/*
  The wires between host and sensor: serial clock, data in, data out
  and the conversion clock. Assumes both ends share no other signal.
*/
`timescale 1ns/1ps

interface sensor_link_if;
  logic sclk;
  logic din;
  logic dout;
  logic mclk;

  modport device (input sclk, input din, input mclk, output dout);
  modport host (output sclk, output din, output mclk, input dout);
endinterface : sensor_link_if

/* File: hw/sensor_host.sv */
/*
  Host end of the sensor link: makes the serial and conversion clocks,
  sends reset pattern plus instruction, waits and reads 16-bit words.
  Assumes the sensor end follows the same framing constants.
*/
`timescale 1ns/1ps
`include "sensor_link_defines.svh"

module sensor_host (
  input wire logic CLOCK,
  input wire logic RST_N,
  sensor_link_if.host LINK,
  input wire logic START,
  input wire logic [2:0] OPERATION,
  output logic BUSY,
  output logic DONE,
  output logic ACK_ERROR,
  output logic [15:0] RESULT
);

  // ****************************************************************
  // Setup code per operation
  // ****************************************************************
  function automatic logic [3:0] setup_code(input logic [2:0] op);
    unique case (op)
      3'h0: setup_code = `SETUP_PRESSURE;
      3'h1: setup_code = `SETUP_TEMPERATURE;
      3'h2: setup_code = `SETUP_CAL_A;
      3'h3: setup_code = `SETUP_CAL_B;
      3'h4: setup_code = `SETUP_CAL_C;
      default: setup_code = `SETUP_CAL_D;
    endcase
  endfunction : setup_code

  // ****************************************************************
  // Dout synchroniser
  // ****************************************************************
  logic dout_meta;
  logic dout_sync;
  logic dout_prev;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      dout_meta <= 1'b0;
      dout_sync <= 1'b0;
      dout_prev <= 1'b0;
    end else begin
      dout_meta <= LINK.dout;
      dout_sync <= dout_meta;
      dout_prev <= dout_sync;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  sensor_link_pkg::host_state_t state;
  sensor_link_pkg::host_state_t next_state;
  logic [2:0] op;
  logic [2:0] next_op;
  logic [4:0] phase;
  logic [4:0] next_phase;
  logic [4:0] bits;
  logic [4:0] next_bits;
  logic [30:0] tx;
  logic [30:0] next_tx;
  logic [15:0] rx;
  logic [15:0] next_rx;
  logic [8:0] mdiv;
  logic [8:0] next_mdiv;
  logic sclk;
  logic next_sclk;
  logic din;
  logic next_din;
  logic mclk;
  logic next_mclk;
  logic next_busy;
  logic next_done;
  logic next_err;
  logic [15:0] next_result;
  logic pulsing;
  logic tick;
  logic fall;
  logic [30:0] frame;

  assign pulsing = (state == sensor_link_pkg::H_FRAME)
                 | (state == sensor_link_pkg::H_TAIL)
                 | (state == sensor_link_pkg::H_READ);
  assign tick = (phase == 5'(`SCLK_HALF_CYCLES - 1));
  assign fall = pulsing & tick & sclk;
  // Reset pattern leads every instruction
  assign frame = {`RESET_PATTERN, `START_MARK, setup_code(START ?
                  OPERATION : op), `STOP_MARK};

  always_comb begin
    next_state = state;
    next_op = op;
    next_phase = pulsing ? (tick ? 5'h00 : phase + 5'h01) : 5'h00;
    next_bits = bits;
    next_tx = tx;
    next_rx = rx;
    next_sclk = sclk;
    next_din = din;
    next_done = 1'b0;
    next_err = ACK_ERROR;
    next_result = RESULT;
    // Conversion clock runs only while a pressure or temperature command is busy
    next_mclk = mclk;
    next_mdiv = mdiv + 9'h001;
    if (mdiv == 9'(`MCLK_HALF_CYCLES - 1)) begin
      next_mdiv = 9'h000;
      next_mclk = ~mclk;
    end
    if (state == sensor_link_pkg::H_IDLE || op[2:1] != 2'h0) begin
      next_mclk = 1'b0;
      next_mdiv = 9'h000;
    end
    if (pulsing && tick) begin
      next_sclk = ~sclk;
    end
    if (fall) begin
      next_bits = bits - 5'h01;
      next_din = tx[30];
      next_tx = {tx[29:0], 1'b0};
    end
    unique case (state)
      sensor_link_pkg::H_IDLE: begin
        if (START) begin
          next_op = OPERATION;
          next_din = frame[30];
          next_tx = {frame[29:0], 1'b0};
          next_bits = `FRAME_PULSES;
          next_err = 1'b0;
          next_state = sensor_link_pkg::H_FRAME;
        end
      end
      sensor_link_pkg::H_FRAME: begin
        // Dout is ignored until the final stop bit
        if (fall && bits == 5'h01) begin
          next_din = 1'b0;
          if (op[2:1] != 2'h0) begin
            next_bits = 5'(`READ_PULSES);
            next_state = sensor_link_pkg::H_READ;
          end else if (!dout_sync) begin
            next_err = 1'b1;
            next_done = 1'b1;
            next_state = sensor_link_pkg::H_IDLE;
          end else begin
            next_bits = 5'(`ACK_TAIL_PULSES);
            next_state = sensor_link_pkg::H_TAIL;
          end
        end
      end
      sensor_link_pkg::H_TAIL: begin
        if (fall && bits == 5'h01) begin
          next_state = sensor_link_pkg::H_WAIT;
        end
      end
      sensor_link_pkg::H_WAIT: begin
        // Serial clock held low until dout falls
        if (dout_prev && !dout_sync) begin
          next_bits = 5'(`READ_PULSES);
          next_state = sensor_link_pkg::H_READ;
        end
      end
      sensor_link_pkg::H_READ: begin
        if (fall) begin
          next_rx = {rx[14:0], dout_sync};
          if (bits == 5'h01) begin
            next_result = rx;
            next_done = 1'b1;
            next_state = sensor_link_pkg::H_IDLE;
          end
        end
      end
      default: begin
        next_state = sensor_link_pkg::H_IDLE;
      end
    endcase
    next_busy = (next_state != sensor_link_pkg::H_IDLE);
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state <= sensor_link_pkg::H_IDLE;
      op <= 3'h0;
      phase <= 5'h00;
      bits <= 5'h00;
      tx <= 31'h00000000;
      rx <= 16'h0000;
      mdiv <= 9'h000;
      sclk <= 1'b0;
      din <= 1'b0;
      mclk <= 1'b0;
      BUSY <= 1'b0;
      DONE <= 1'b0;
      ACK_ERROR <= 1'b0;
      RESULT <= 16'h0000;
    end else begin
      state <= next_state;
      op <= next_op;
      phase <= next_phase;
      bits <= next_bits;
      tx <= next_tx;
      rx <= next_rx;
      mdiv <= next_mdiv;
      sclk <= next_sclk;
      din <= next_din;
      mclk <= next_mclk;
      BUSY <= next_busy;
      DONE <= next_done;
      ACK_ERROR <= next_err;
      RESULT <= next_result;
    end
  end

  assign LINK.sclk = sclk;
  assign LINK.din = din;
  assign LINK.mclk = mclk;

endmodule : sensor_host

/* File: tb/sensor_link_monitor.sv */
/*
  Checker for the wires between host and sensor, fed with plain copies
  of the link signals. Assumes one 20 MHz clock and a sync reset.
*/
`timescale 1ns/1ps
`include "sensor_link_defines.svh"

module sensor_link_monitor #(
  parameter int CONV_EDGES = 6
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic mclk
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  // ****************************************************************
  // Helper counters
  // ****************************************************************
  logic sclk_q;
  logic mclk_q;
  logic sclk_up;
  logic [7:0] since_rise;
  logic [7:0] high_cnt;
  logic [7:0] low_cnt;
  logic [15:0] mrises;
  logic [20:0] hist;
  logic [7:0] next_since_rise;
  logic [7:0] next_high_cnt;
  logic [7:0] next_low_cnt;
  logic [15:0] next_mrises;
  logic [20:0] next_hist;

  assign sclk_up = sclk && !sclk_q;

  // since_rise and low_cnt saturate so a long conversion wait never wraps them
  always_comb begin
    next_since_rise = (since_rise == 8'hff) ? since_rise : since_rise + 8'h01;
    next_high_cnt = sclk ? high_cnt + 8'h01 : 8'h00;
    next_low_cnt = sclk ? 8'h00 :
      ((low_cnt == 8'hff) ? low_cnt : low_cnt + 8'h01);
    next_mrises = (mclk && !mclk_q) ? mrises + 16'h0001 : mrises;
    next_hist = hist;
    if (sclk_up) begin
      next_since_rise = 8'h00;
      next_mrises = 16'h0000;
      next_hist = {hist[19:0], din};
    end
  end

  // Registered copies only
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      sclk_q <= 1'b0;
      mclk_q <= 1'b0;
      since_rise <= 8'hff;
      high_cnt <= 8'h00;
      low_cnt <= 8'hff;
      mrises <= 16'h0000;
      hist <= 21'h000000;
    end else begin
      sclk_q <= sclk;
      mclk_q <= mclk;
      since_rise <= next_since_rise;
      high_cnt <= next_high_cnt;
      low_cnt <= next_low_cnt;
      mrises <= next_mrises;
      hist <= next_hist;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  dout_launch_a:
    assert property ($rose(dout) |-> since_rise inside {[1:5]})
    else $error("dout rose away from a serial clock rise");
  clock_high_a:
    assert property ($fell(sclk) |-> high_cnt == `SCLK_HALF_CYCLES)
    else $error("serial clock high phase has the wrong length");
  clock_low_a:
    assert property ($rose(sclk) |-> low_cnt >= `SCLK_HALF_CYCLES)
    else $error("serial clock low phase too short");
  din_hold_a:
    assert property (sclk |-> $stable(din))
    else $error("din moved while serial clock high");
  quiet_conversion_a:
    assert property ($rose(sclk) |-> !(dout && low_cnt > 8'h64))
    else $error("serial clock restarted during a conversion");
  ack_edge_a:
    assert property (since_rise == 8'h08 &&
      (hist[9:0] == {`START_MARK, `SETUP_PRESSURE, `STOP_MARK} ||
       hist[9:0] == {`START_MARK, `SETUP_TEMPERATURE, `STOP_MARK})
      |-> dout && !$past(dout, 8))
    else $error("no acknowledge on the last stop bit");
  conversion_length_a:
    assert property ($fell(dout) && since_rise > 8'h28 |->
      mrises >= CONV_EDGES && mrises <= CONV_EDGES + 1)
    else $error("conversion end after the wrong number of ticks");
  reset_pattern_a:
    assert property (since_rise == 8'h08 && hist == `RESET_PATTERN |-> !dout)
    else $error("dout not low after the reset pattern");
endmodule : sensor_link_monitor

/* File: tb/tb.sv */
/*
  Self-checking bench: host and sensor face each other on one link,
  a second sensor is driven by hand on a spare link.
  Assumes a 20 MHz clock and the shared framing constants.
*/
`timescale 1ns/1ps
`include "sensor_link_defines.svh"

module tb;
  localparam int CONV = 12;
  localparam logic [15:0] CAL [4] = '{`CAL_SLOT_A_INIT, `CAL_SLOT_B_INIT,
    `CAL_SLOT_C_INIT, `CAL_SLOT_D_INIT};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [2:0] operation = 3'h0;
  logic [15:0] pressure_level = 16'h2345;
  logic [15:0] temperature_level = 16'h8000;
  logic busy;
  logic done;
  logic ack_error;
  logic [15:0] result;
  logic bridge_power;
  logic converting;
  int errors = 0;
  int checks = 0;
  int conv_cycles = 0;
  int bridge_cycles = 0;

  // ****************************************************************
  // Structure
  // ****************************************************************
  sensor_link_if main_link ();
  sensor_link_if spare_link ();

  sensor_device #(.CONV_EDGES(CONV)) sensor_device_i (.CLOCK(clock),
    .RST_N(rst_n), .LINK(main_link), .PRESSURE_LEVEL(pressure_level),
    .TEMPERATURE_LEVEL(temperature_level), .BRIDGE_POWER(bridge_power),
    .CONVERTING(converting));
  sensor_host sensor_host_i (.CLOCK(clock), .RST_N(rst_n),
    .LINK(main_link), .START(start), .OPERATION(operation), .BUSY(busy),
    .DONE(done), .ACK_ERROR(ack_error), .RESULT(result));
  sensor_device #(.CONV_EDGES(CONV)) spare_sensor_device_i (.CLOCK(clock),
    .RST_N(rst_n), .LINK(spare_link), .PRESSURE_LEVEL(pressure_level),
    .TEMPERATURE_LEVEL(temperature_level), .BRIDGE_POWER(),
    .CONVERTING());
  sensor_link_monitor #(.CONV_EDGES(CONV)) sensor_link_monitor_i (
    .CLOCK(clock), .RST_N(rst_n), .sclk(main_link.sclk),
    .din(main_link.din), .dout(main_link.dout), .mclk(main_link.mclk));

  always #25 clock = ~clock;

  // Bridge duty, measured against time spent converting
  always @(posedge clock) begin
    if (converting === 1'b1) conv_cycles++;
    if (bridge_power === 1'b1) bridge_cycles++;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      errors++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // One cycle of a bounded wait; a hang ends the run
  task automatic tick(inout int n);
    @(posedge clock);
    n++;
    if (n > 20000) begin
      errors++;
      complete_run();
    end
  endtask : tick

  // Command through the host; a second START while busy must be ignored
  task automatic run_host(input logic [2:0] op, input logic [15:0] want);
    int n = 0;
    @(posedge clock);
    while (busy !== 1'b0) tick(n);
    operation <= op;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    repeat (3) @(posedge clock);
    check({15'h0, busy}, 16'h0001);
    operation <= op ^ 3'h1;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    while (done !== 1'b1) tick(n);
    check(result, want);
    check({15'h0, ack_error}, 16'h0000);
  endtask : run_host

  // Spare link bit: change din after the fall, sample dout before it
  task automatic spare_bit(input logic b, output logic q);
    @(posedge clock);
    spare_link.din <= b;
    repeat (4) @(posedge clock);
    spare_link.sclk <= 1'b1;
    repeat (8) @(posedge clock);
    q = spare_link.dout;
    spare_link.sclk <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : spare_bit

  task automatic spare_frame(input logic [3:0] code);
    logic [9:0] bits;
    logic q;
    bits = {`START_MARK, code, `STOP_MARK};
    for (int i = 9; i >= 0; i--) spare_bit(bits[i], q);
  endtask : spare_frame

  task automatic spare_pattern();
    logic [20:0] bits;
    logic q;
    bits = `RESET_PATTERN;
    for (int i = 20; i >= 0; i--) spare_bit(bits[i], q);
  endtask : spare_pattern

  task automatic spare_read(input int count, inout logic [15:0] word);
    logic q;
    for (int i = 0; i < count; i++) begin
      spare_bit(1'b0, q);
      word = {word[14:0], q};
    end
  endtask : spare_read

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_cal_words();
    for (int k = 0; k < 4; k++) begin
      run_host(3'(sensor_link_pkg::OP_CAL_A) + 3'(k), CAL[k]);
    end
    $display("calibration word test done");
  endtask : test_cal_words

  // Both channels, with levels on and past the clamp limits
  task automatic test_conversions();
    logic [15:0] levels [6] = '{16'h2345, 16'h8000, 16'h0010, 16'hffff,
      16'h9088, 16'h1388};
    logic [15:0] want;
    for (int i = 0; i < 6; i++) begin
      pressure_level <= i[0] ? ~levels[i] : levels[i];
      temperature_level <= i[0] ? levels[i] : ~levels[i];
      want = (levels[i] < `RESULT_MIN) ? `RESULT_MIN :
        ((levels[i] > `RESULT_MAX) ? `RESULT_MAX : levels[i]);
      run_host(i[0] ? sensor_link_pkg::OP_TEMPERATURE :
        sensor_link_pkg::OP_PRESSURE, want);
    end
    check({15'h0, bridge_cycles > 0 && bridge_cycles * 8 < conv_cycles},
      16'h0001);
    $display("conversion test done");
  endtask : test_conversions

  // Unknown code, paused readout, reset pattern mid readout and mid
  // conversion; spare mclk stays low, so only the pattern ends it
  task automatic test_spare_link();
    logic [15:0] word;
    logic q;
    word = 16'h0000;
    spare_pattern();
    spare_frame(4'h3);
    spare_frame(`SETUP_CAL_C);
    spare_read(5, word);
    repeat (40) @(posedge clock);
    spare_read(11, word);
    check(word, `CAL_SLOT_C_INIT);
    spare_bit(1'b0, q);
    check({15'h0, q}, 16'h0000);
    spare_frame(`SETUP_CAL_B);
    spare_read(3, word);
    spare_pattern();
    check({15'h0, spare_link.dout}, 16'h0000);
    spare_frame(`SETUP_PRESSURE);
    check({15'h0, spare_link.dout}, 16'h0001);
    spare_read(2, word);
    spare_pattern();
    check({15'h0, spare_link.dout}, 16'h0000);
    spare_frame(`SETUP_CAL_D);
    spare_read(16, word);
    check(word, `CAL_SLOT_D_INIT);
    $display("spare link test done");
  endtask : test_spare_link

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    spare_link.sclk = 1'b0;
    spare_link.din = 1'b0;
    spare_link.mclk = 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    test_cal_words();
    test_conversions();
    test_spare_link();
    complete_run();
  end
endmodule : tb
